// *** src/acn_pkg.sv ***
package acn_pkg;
    localparam int unsigned FUNC_W            = 5;
    localparam int unsigned SET_W             = 24;
    localparam int unsigned CHECK_W           = 8;
    localparam int unsigned CHAN_W            = 8;
    localparam logic [4:0]  FUNC_ENTRY        = 5'h00;
    localparam logic [4:0]  FUNC_MAX          = 5'h18;
    localparam logic [4:0]  FUNC_GROUP_FIRST  = 5'h15;
    localparam logic [4:0]  AUTO_RESET_FUNCTION   = 5'h03;
    localparam logic [4:0]  HORN_GROUP_A_FUNCTION = 5'h17;
    localparam logic [7:0]  CHECK_SEED        = 8'h5a;
    localparam logic [11:0] ADDR_CTRL         = 12'h000;
    localparam logic [11:0] ADDR_STATUS       = 12'h004;
    localparam logic [11:0] ADDR_SETTINGS     = 12'h008;
    localparam logic [31:0] CTRL_RESET        = 32'h0000_0001;
    localparam int unsigned CTRL_ENABLE_BIT   = 0;
    localparam int unsigned STAT_CHAN_LSB     = 0;
    localparam int unsigned STAT_FUNC_LSB     = 8;
    localparam int unsigned STAT_STATE_LSB    = 16;
    localparam int unsigned STAT_WREJ_BIT     = 24;
    localparam int unsigned STAT_RREJ_BIT     = 25;
    localparam int unsigned CLK_PERIOD_NS     = 50;
    localparam int unsigned FLASH_HALF_NS     = 125_000_000;
    localparam int unsigned FLASH_HALF_CYC    = FLASH_HALF_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0]
    {
        ACN_IDLE   = 2'b00,
        ACN_LOAD   = 2'b01,
        ACN_EDIT   = 2'b11,
        ACN_COMMIT = 2'b10
    } acn_state_t;

    typedef struct packed
    {
        logic               we;
        logic [CHAN_W-1:0]  chan;
        logic [SET_W-1:0]   data;
        logic [CHECK_W-1:0] check;
    } acn_nv_cmd_t;

    // Cheap fold; it catches single bit faults and bursts of up to 8 bits on the card link, not longer bursts.
    function automatic logic [CHECK_W-1:0] acn_check(input logic [SET_W-1:0] d);
        return d[7:0] ^ d[15:8] ^ d[23:16] ^ CHECK_SEED;
    endfunction : acn_check
endpackage : acn_pkg

// *** src/acn_navigator.sv ***
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module acn_navigator
    import acn_pkg::*;
#(
    parameter int unsigned NCH        = 16,
    parameter int unsigned FLASH_HALF = FLASH_HALF_CYC
)
(
    input  wire logic              sys_clk_i,
    input  wire logic              rst_i,
    input  wire logic              ce_i,
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [11:0]       paddr_i,
    input  wire logic [31:0]       pwdata_i,
    output logic [31:0]            prdata_o,
    output logic                   pready_o,
    output logic                   pslverr_o,
    input  wire logic              config_mode_switch_i,
    input  wire logic              channel_down_button_i,
    input  wire logic              channel_up_button_i,
    input  wire logic              reset_button_i,
    input  wire logic              first_reset_button_i,
    input  wire logic              ack_button_i,
    input  wire logic              mute_button_i,
    input  wire logic [NCH-1:0]    alarm_window_i,
    input  wire logic [NCH/2-1:0]  card_present_i,
    output logic                   nv_req_o,
    output acn_nv_cmd_t            nv_cmd_o,
    input  wire logic              nv_ack_i,
    input  wire logic              nv_err_i,
    input  wire logic [SET_W-1:0]  nv_rdata_i,
    input  wire logic [CHECK_W-1:0] nv_rcheck_i,
    output logic [FUNC_W-1:0]      function_display_o,
    output logic                   status_lamp_o,
    output logic [NCH-1:0]         window_o
);
    localparam int unsigned CH_W = $clog2(NCH);

    acn_state_t         state_reg;
    logic [CH_W-1:0]    sel_reg;
    logic [CH_W-1:0]    pend_reg;
    logic [FUNC_W-1:0]  func_reg;
    logic [SET_W-1:0]   edit_reg;
    logic [3:0]         grp_reg [NCH];
    logic [31:0]        ctrl_reg;
    logic               wrej_reg;
    logic               rrej_reg;
    logic [5:0]         btn_prev_reg;
    logic [31:0]        flash_cnt_reg;
    logic               flash_reg;
    logic [NCH-1:0]     win_next;
    logic [CH_W:0]      seek_res;
    logic [5:0]         btn_now;
    logic [5:0]         press;
    logic               cfg_on;
    logic               move_req;
    logic               move_go;
    logic               edit_go;
    logic               is_group;
    logic [1:0]         gidx;
    logic               apb_wr;
    logic               stat_clr_w;
    logic               stat_clr_r;

    // Walk outward from the current channel; cards hold channel pairs.
    function automatic logic [CH_W:0] seek(input logic [CH_W-1:0] from, input logic up,
                                           input logic skip, input logic [NCH/2-1:0] pres);
        logic [CH_W:0] res;
        logic          done;
        int            c;
        res  = {1'b0, from};
        done = 1'b0;
        c    = 0;
        for (int i = 1; i < NCH; i++)
        begin
            c = up ? int'(from) + i : int'(from) - i;
            if (!done && c >= 0 && c < int'(NCH))
            begin
                if (pres[c / 2])
                begin
                    res  = {1'b1, CH_W'(c)};
                    done = 1'b1;
                end
                else if (!skip)
                begin
                    done = 1'b1;
                end
            end
        end
        return res;
    endfunction : seek

    assign btn_now  = {mute_button_i, ack_button_i, first_reset_button_i,
                       reset_button_i, channel_up_button_i, channel_down_button_i};
    assign press    = btn_now & ~btn_prev_reg;
    assign cfg_on   = config_mode_switch_i & ctrl_reg[CTRL_ENABLE_BIT];
    assign move_req = press[1] | press[0];
    // Channel up wins if both arrive together; ascending index is the standard order.
    assign seek_res = seek(sel_reg, press[1], reset_button_i, card_present_i);
    assign move_go  = ce_i && state_reg == ACN_EDIT && cfg_on && move_req && seek_res[CH_W];
    assign edit_go  = ce_i && state_reg == ACN_EDIT && cfg_on && !move_go;
    assign is_group = func_reg >= FUNC_GROUP_FIRST && func_reg <= FUNC_MAX;
    assign gidx     = 2'(func_reg - FUNC_GROUP_FIRST);

    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            btn_prev_reg <= 6'h00;
        else if (ce_i)
            btn_prev_reg <= btn_now;
    end

    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_reg <= ACN_IDLE;
            sel_reg   <= '0;
            pend_reg  <= '0;
            nv_cmd_o  <= '0;
            edit_reg  <= '0;
        end
        else if (ce_i)
        begin
            case (state_reg)
                ACN_IDLE:
                    if (cfg_on)
                    begin
                        state_reg   <= ACN_LOAD;
                        nv_cmd_o    <= '0;
                        nv_cmd_o.chan <= CHAN_W'(sel_reg);
                    end
                ACN_LOAD:
                    if (nv_ack_i)
                    begin
                        state_reg <= cfg_on ? ACN_EDIT : ACN_IDLE;
                        edit_reg  <= (acn_check(nv_rdata_i) == nv_rcheck_i) ? nv_rdata_i
                                                                            : '0;
                    end
                ACN_EDIT:
                    if (!cfg_on)
                        state_reg <= ACN_IDLE;
                    else if (move_go)
                    begin
                        state_reg      <= ACN_COMMIT;
                        pend_reg       <= seek_res[CH_W-1:0];
                        nv_cmd_o.we    <= 1'b1;
                        nv_cmd_o.chan  <= CHAN_W'(sel_reg);
                        nv_cmd_o.data  <= edit_reg;
                        nv_cmd_o.check <= acn_check(edit_reg);
                    end
                    else if (edit_go && func_reg != FUNC_ENTRY)
                    begin
                        if (press[5])
                            edit_reg[func_reg - 5'h01] <= 1'b1;
                        else if (press[4])
                            edit_reg[func_reg - 5'h01] <= 1'b0;
                    end
                ACN_COMMIT:
                    if (nv_ack_i)
                    begin
                        nv_cmd_o.we <= 1'b0;
                        if (nv_err_i)
                            state_reg <= ACN_EDIT;
                        else
                        begin
                            state_reg     <= ACN_LOAD;
                            sel_reg       <= pend_reg;
                            nv_cmd_o.chan <= CHAN_W'(pend_reg);
                            nv_cmd_o.data <= '0;
                        end
                    end
                default:
                    state_reg <= ACN_IDLE;
            endcase
        end
    end

    assign nv_req_o = state_reg == ACN_LOAD || state_reg == ACN_COMMIT;

    // Group shadow lets every window except the selected one show a group without reading every card.
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            for (int i = 0; i < NCH; i++)
                grp_reg[i] <= 4'h0;
        end
        else if (ce_i && nv_ack_i)
        begin
            if (state_reg == ACN_LOAD && acn_check(nv_rdata_i) == nv_rcheck_i)
                grp_reg[sel_reg] <= nv_rdata_i[SET_W-1:SET_W-4];
            else if (state_reg == ACN_COMMIT && !nv_err_i)
                grp_reg[sel_reg] <= edit_reg[SET_W-1:SET_W-4];
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            func_reg <= FUNC_ENTRY;
        else if (ce_i)
        begin
            if (state_reg == ACN_IDLE)
                func_reg <= FUNC_ENTRY;
            else if (edit_go && press[3] && func_reg < FUNC_MAX)
                func_reg <= func_reg + 5'h01;
            else if (edit_go && press[2] && !press[3] && func_reg > FUNC_ENTRY)
                func_reg <= func_reg - 5'h01;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            flash_cnt_reg <= 32'h0000_0000;
            flash_reg     <= 1'b0;
        end
        else if (ce_i)
        begin
            if (flash_cnt_reg >= FLASH_HALF - 1)
            begin
                flash_cnt_reg <= 32'h0000_0000;
                flash_reg     <= ~flash_reg;
            end
            else
                flash_cnt_reg <= flash_cnt_reg + 32'h0000_0001;
        end
    end

    always_comb
    begin
        for (int i = 0; i < NCH; i++)
        begin
            if (state_reg == ACN_IDLE)
                win_next[i] = alarm_window_i[i];
            else if (CH_W'(i) == sel_reg)
                win_next[i] = flash_reg;
            else if (is_group)
                win_next[i] = grp_reg[i][gidx];
            else
                win_next[i] = alarm_window_i[i];
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            window_o           <= '0;
            function_display_o <= FUNC_ENTRY;
        end
        else if (ce_i)
        begin
            window_o           <= win_next;
            function_display_o <= (state_reg == ACN_IDLE) ? FUNC_ENTRY : func_reg;
        end
    end

    // Lamp follows the edit copy, so it changes the cycle after a press.
    assign status_lamp_o = state_reg == ACN_EDIT && func_reg != FUNC_ENTRY
                           && edit_reg[func_reg - 5'h01];

    assign apb_wr     = ce_i && psel_i && penable_i && pwrite_i;
    assign stat_clr_w = apb_wr && paddr_i == ADDR_STATUS && pwdata_i[STAT_WREJ_BIT];
    assign stat_clr_r = apb_wr && paddr_i == ADDR_STATUS && pwdata_i[STAT_RREJ_BIT];

    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            ctrl_reg <= CTRL_RESET;
        else if (apb_wr && paddr_i == ADDR_CTRL)
            ctrl_reg <= {31'h0000_0000, pwdata_i[CTRL_ENABLE_BIT]};
    end

    // A new rejection in the clearing cycle survives the clear.
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wrej_reg <= 1'b0;
            rrej_reg <= 1'b0;
        end
        else if (ce_i)
        begin
            if (state_reg == ACN_COMMIT && nv_ack_i && nv_err_i)
                wrej_reg <= 1'b1;
            else if (stat_clr_w)
                wrej_reg <= 1'b0;
            if (state_reg == ACN_LOAD && nv_ack_i && acn_check(nv_rdata_i) != nv_rcheck_i)
                rrej_reg <= 1'b1;
            else if (stat_clr_r)
                rrej_reg <= 1'b0;
        end
    end

    assign pready_o = 1'b1;

    always_comb
    begin
        prdata_o  = 32'h0000_0000;
        pslverr_o = 1'b0;
        if (paddr_i == ADDR_CTRL)
            prdata_o = ctrl_reg;
        else if (paddr_i == ADDR_STATUS)
        begin
            prdata_o[STAT_CHAN_LSB +: CH_W] = sel_reg;
            prdata_o[STAT_FUNC_LSB +: FUNC_W] = func_reg;
            prdata_o[STAT_STATE_LSB +: 2] = state_reg;
            prdata_o[STAT_WREJ_BIT] = wrej_reg;
            prdata_o[STAT_RREJ_BIT] = rrej_reg;
        end
        else if (paddr_i == ADDR_SETTINGS)
            prdata_o[SET_W-1:0] = edit_reg;
        else
            pslverr_o = psel_i & penable_i;
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    property p_entry_zero;
        state_reg == ACN_IDLE && cfg_on && ce_i |=> function_display_o == FUNC_ENTRY;
    endproperty
    a_entry_zero: assert property (p_entry_zero) else $error("display not zero on entry");

    property p_sel_flash;
        state_reg == ACN_EDIT && ce_i |=> window_o[$past(sel_reg)] == $past(flash_reg);
    endproperty
    a_sel_flash: assert property (p_sel_flash) else $error("selected window not flashing");

    property p_move;
        move_go |=> state_reg == ACN_COMMIT && pend_reg == $past(seek_res[CH_W-1:0]);
    endproperty
    a_move: assert property (p_move) else $error("channel move not taken");

    property p_func_up;
        edit_go && press[3] && func_reg < FUNC_MAX |=> func_reg == $past(func_reg) + 5'h01;
    endproperty
    a_func_up: assert property (p_func_up) else $error("function did not step up");

    property p_mute_sets;
        edit_go && press[5] && func_reg != FUNC_ENTRY && !press[3] && !press[2]
            |=> status_lamp_o;
    endproperty
    a_mute_sets: assert property (p_mute_sets) else $error("mute did not set lamp");

    property p_discard;
        state_reg == ACN_EDIT && !cfg_on && ce_i |=> state_reg == ACN_IDLE && !nv_req_o;
    endproperty
    a_discard: assert property (p_discard) else $error("exit did not discard");

    property p_commit;
        move_go |=> nv_req_o && nv_cmd_o.we && nv_cmd_o.chan == CHAN_W'($past(sel_reg));
    endproperty
    a_commit: assert property (p_commit) else $error("move did not commit");

    property p_stop;
        state_reg == ACN_EDIT && cfg_on && ce_i && move_req && !seek_res[CH_W]
            |=> $stable(sel_reg) && state_reg == ACN_EDIT;
    endproperty
    a_stop: assert property (p_stop) else $error("moved past missing card");

    property p_reject;
        state_reg == ACN_COMMIT && ce_i && nv_ack_i && nv_err_i
            |=> state_reg == ACN_EDIT && wrej_reg && $stable(sel_reg);
    endproperty
    a_reject: assert property (p_reject) else $error("bad commit not rejected");

    property p_load;
        state_reg == ACN_COMMIT && ce_i && nv_ack_i && !nv_err_i
            |=> state_reg == ACN_LOAD && !nv_cmd_o.we && sel_reg == $past(pend_reg);
    endproperty
    a_load: assert property (p_load) else $error("new channel not loaded");

    c_commit: cover property (state_reg == ACN_COMMIT && nv_ack_i && !nv_err_i);
    c_skip: cover property (move_go && reset_button_i);
    c_group: cover property (state_reg == ACN_EDIT && is_group);
    c_reject: cover property (state_reg == ACN_COMMIT && nv_ack_i && nv_err_i);
endmodule : acn_navigator
`default_nettype wire

// *** tb/acn_card_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module acn_card_model
    import acn_pkg::*;
#(
    parameter int unsigned NCH = 16
)
(
    input  wire logic                sys_clk_i,
    input  wire logic                rst_i,
    input  wire logic [3:0]          delay_i,
    input  wire logic                err_wr_i,
    input  wire logic                bad_rd_i,
    input  wire logic                nv_req_i,
    input  wire acn_nv_cmd_t         nv_cmd_i,
    output logic                     nv_ack_o,
    output logic                     nv_err_o,
    output logic [SET_W-1:0]         nv_rdata_o,
    output logic [CHECK_W-1:0]       nv_rcheck_o
);
    logic [SET_W-1:0] mem [NCH];
    logic [3:0]       wait_reg;

    // The card keeps its own copy of the fold so a wrong design copy cannot hide.
    function automatic logic [CHECK_W-1:0] card_check(input logic [SET_W-1:0] d);
        return d[7:0] ^ d[15:8] ^ d[23:16] ^ 8'h5a;
    endfunction : card_check

    // Plain always so the bench may preload the card memory.
    always @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wait_reg    <= 4'h0;
            nv_ack_o    <= 1'b0;
            nv_err_o    <= 1'b0;
            nv_rdata_o  <= 24'h000000;
            nv_rcheck_o <= 8'h00;
        end
        else
        begin
            nv_ack_o    <= 1'b0;
            nv_err_o    <= 1'b0;
            // Released data lines toggle so a stale value is never mistaken for an answer.
            nv_rdata_o  <= ~nv_rdata_o;
            nv_rcheck_o <= ~nv_rcheck_o;
            if (nv_req_i && !nv_ack_o)
            begin
                wait_reg <= wait_reg + 4'h1;
                if (wait_reg >= delay_i)
                begin
                    wait_reg <= 4'h0;
                    nv_ack_o <= 1'b1;
                    if (nv_cmd_i.we)
                    begin
                        if (err_wr_i || nv_cmd_i.check !== card_check(nv_cmd_i.data))
                            nv_err_o <= 1'b1;
                        else
                            mem[nv_cmd_i.chan] <= nv_cmd_i.data;
                    end
                    else
                    begin
                        nv_rdata_o  <= mem[nv_cmd_i.chan];
                        nv_rcheck_o <= card_check(mem[nv_cmd_i.chan]) ^ {7'h00, bad_rd_i};
                    end
                end
            end
        end
    end
endmodule : acn_card_model
`default_nettype wire

// *** tb/alarm_channel_config_navigator_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module alarm_channel_config_navigator_tb_top;
    import acn_pkg::*;
    localparam int unsigned NCH = 16;
    localparam int unsigned FH  = 4;
    logic               sys_clk_i, rst_i, psel, penable, pwrite, pready, pslverr;
    logic               sw, nv_req, nv_ack, nv_err, lamp, err_wr, bad_rd, perr, ce;
    logic [11:0]        paddr;
    logic [31:0]        pwdata, prdata, r;
    logic [5:0]         btn;
    logic [NCH-1:0]     aw, win;
    logic [7:0]         present;
    logic [3:0]         delay;
    logic [4:0]         disp;
    logic [SET_W-1:0]   rdata, edit;
    logic [CHECK_W-1:0] rcheck;
    acn_nv_cmd_t        cmd;
    logic [SET_W-1:0]   mem_m [NCH];
    int                 sel, func, num_errors, tests_run;

    initial
    begin
        sys_clk_i = 1'b0;
        forever #25 sys_clk_i = ~sys_clk_i;
    end

    acn_navigator #(.NCH(NCH), .FLASH_HALF(FH)) dut_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .ce_i(ce), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .config_mode_switch_i(sw), .channel_down_button_i(btn[0]),
        .channel_up_button_i(btn[1]), .reset_button_i(btn[2]), .first_reset_button_i(btn[3]),
        .ack_button_i(btn[4]), .mute_button_i(btn[5]), .alarm_window_i(aw),
        .card_present_i(present), .nv_req_o(nv_req), .nv_cmd_o(cmd), .nv_ack_i(nv_ack),
        .nv_err_i(nv_err), .nv_rdata_i(rdata), .nv_rcheck_i(rcheck),
        .function_display_o(disp), .status_lamp_o(lamp), .window_o(win));

    acn_card_model #(.NCH(NCH)) card_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .delay_i(delay), .err_wr_i(err_wr), .bad_rd_i(bad_rd), .nv_req_i(nv_req),
        .nv_cmd_i(cmd), .nv_ack_o(nv_ack), .nv_err_o(nv_err), .nv_rdata_o(rdata),
        .nv_rcheck_o(rcheck));

    task automatic wrap_up();
        $display("mismatches %0d of %0d checks", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : wrap_up

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        @(posedge sys_clk_i);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk_i);
        penable <= 1'b1;
        // Request stands until pready is seen high at a rising edge; data is taken there.
        do
            @(posedge sys_clk_i);
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [11:0] a, output logic [31:0] q);
        logic e;
        apb(1'b0, a, 32'h0000_0000, q, e);
    endtask : rd

    task automatic press(input int i);
        @(posedge sys_clk_i);
        btn[i] <= 1'b1;
        @(posedge sys_clk_i);
        btn[i] <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
    endtask : press

    // Index 2/3 step the function down/up, 4/5 clear/set its bit.
    task automatic op(input int k);
        press(k);
        if (k == 2 && func > 0)
            func--;
        if (k == 3 && func < 24)
            func++;
        if (k >= 4 && func != 0)
            edit[func-1] = (k == 5);
    endtask : op

    task automatic check_view();
        logic [31:0] q;
        q = 32'h0000_0000;
        repeat (40)
            if (q[17:16] !== 2'b11)
                rd(ADDR_STATUS, q);
        `CHK(q[7:0], sel[7:0])
        `CHK(q[12:8], func[4:0])
        `CHK(disp, func[4:0])
        `CHK(lamp, (func == 0) ? 1'b0 : edit[func-1])
        rd(ADDR_SETTINGS, q);
        `CHK(q[23:0], edit)
    endtask : check_view

    task automatic move(input logic up, input logic skip, input logic werr);
        int nxt, old;
        old = sel;
        nxt = sel;
        // Absent cards are hopped only while the reset button is held.
        do nxt = up ? nxt + 1 : nxt - 1;
        while (skip && nxt >= 0 && nxt < NCH && !present[nxt/2]);
        delay <= 4'($urandom % 6);
        press(up ? 1 : 0);
        if (nxt >= 0 && nxt < NCH && present[nxt/2] && !werr)
        begin
            mem_m[old] = edit;
            sel = nxt;
            edit = bad_rd ? 24'h000000 : mem_m[sel];
        end
        check_view();
        `CHK(card_u.mem[old], mem_m[old])
    endtask : move

    task automatic flash_check();
        logic v;
        int   n;
        for (int k = 0; k < 2; k++)
        begin
            @(negedge sys_clk_i);
            v = win[sel];
            n = 1;
            while (win[sel] === v && n < 20)
            begin
                @(negedge sys_clk_i);
                n++;
            end
        end
        `CHK(n, FH)
    endtask : flash_check

    initial
    begin
        repeat (20000) @(posedge sys_clk_i);
        num_errors++;
        wrap_up();
    end

    initial
    begin
        void'($urandom(42711));
        {rst_i, ce, psel, penable, pwrite, sw, err_wr, bad_rd} = 8'hc0;
        {paddr, pwdata, btn, delay} = '0;
        aw = 16'($urandom);
        present = 8'hfb;
        {num_errors, tests_run, sel, func} = '0;
        for (int i = 0; i < NCH; i++)
        begin
            mem_m[i] = 24'($urandom) & 24'hffffef;
            card_u.mem[i] = mem_m[i];
        end
        repeat (6) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        @(negedge sys_clk_i);
        `CHK({win, disp, nv_req, lamp}, 23'h000000)
        rd(ADDR_CTRL, r);
        `CHK(r, CTRL_RESET)
        rd(ADDR_STATUS, r);
        `CHK(r, 32'h0000_0000)
        apb(1'b0, 12'h00c, 32'h0000_0000, r, perr);
        `CHK({perr, r}, 33'h1_0000_0000)
        apb(1'b1, ADDR_CTRL, 32'h0000_0000, r, perr);
        sw <= 1'b1;
        rd(ADDR_STATUS, r);
        `CHK(r[17:16], 2'b00)
        apb(1'b1, ADDR_CTRL, 32'h0000_0001, r, perr);
        edit = mem_m[0];
        check_view();
        flash_check();
        `CHK(win[15], aw[15])
        // With the enable low the flash must hold still for longer than a half period.
        @(posedge sys_clk_i);
        ce <= 1'b0;
        @(posedge sys_clk_i);
        r[15:0] = win;
        repeat (8) @(posedge sys_clk_i);
        `CHK(win, r[15:0])
        ce <= 1'b1;
        while (func < AUTO_RESET_FUNCTION)
            op(3);
        op(5);
        check_view();
        op(4);
        check_view();
        op(5);
        @(posedge sys_clk_i);
        sw <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        `CHK(win, aw)
        `CHK(disp, 5'h00)
        `CHK(card_u.mem[0], mem_m[0])
        sw <= 1'b1;
        func = 0;
        edit = mem_m[0];
        check_view();
        while (func < AUTO_RESET_FUNCTION)
            op(3);
        op(5);
        move(1'b1, 1'b0, 1'b0);
        while (func < HORN_GROUP_A_FUNCTION)
            op(3);
        op(5);
        move(1'b1, 1'b0, 1'b0);
        `CHK({win[15], win[1:0]}, {2'b01, mem_m[0][22]})
        move(1'b0, 1'b0, 1'b0);
        repeat (3) move(1'b1, 1'b0, 1'b0);
        @(posedge sys_clk_i);
        btn[2] <= 1'b1;
        func--;
        repeat (2) @(posedge sys_clk_i);
        move(1'b1, 1'b1, 1'b0);
        btn[2] <= 1'b0;
        repeat (3) op(3);
        op(5);
        check_view();
        err_wr <= 1'b1;
        move(1'b1, 1'b0, 1'b1);
        rd(ADDR_STATUS, r);
        `CHK(r[STAT_WREJ_BIT], 1'b1)
        apb(1'b1, ADDR_STATUS, 32'h0100_0000, r, perr);
        rd(ADDR_STATUS, r);
        `CHK(r[STAT_WREJ_BIT], 1'b0)
        err_wr <= 1'b0;
        move(1'b1, 1'b0, 1'b0);
        bad_rd <= 1'b1;
        move(1'b0, 1'b0, 1'b0);
        rd(ADDR_STATUS, r);
        `CHK(r[STAT_RREJ_BIT], 1'b1)
        wrap_up();
    end
endmodule : alarm_channel_config_navigator_tb_top
`default_nettype wire
